//--- hdl/dma_controller.sv
// four-channel dma controller with its memory-to-memory byte fifo
module byte_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 8
) (
    input  wire logic             clk,
    input  wire logic             rst_n,
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic [WIDTH-1:0]      out_data
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0]    wr_reg, rd_reg;
    logic [AW:0]      fill_reg;
    logic             push, pop;

    assign in_ready  = (fill_reg != (AW+1)'(DEPTH));
    assign out_valid = (fill_reg != '0);
    assign out_data  = mem[rd_reg];
    assign push      = in_valid & in_ready;
    assign pop       = out_valid & out_ready;

    always_ff @(posedge clk) begin
        if (push) begin
            mem[wr_reg] <= in_data;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wr_reg   <= '0;
            rd_reg   <= '0;
            fill_reg <= '0;
        end else begin
            wr_reg   <= push ? AW'(wr_reg + 1'b1) : wr_reg;
            rd_reg   <= pop ? AW'(rd_reg + 1'b1) : rd_reg;
            fill_reg <= (AW+1)'(fill_reg + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop});
        end
    end
endmodule : byte_fifo

module dma_controller (
    input  wire logic      clk,
    input  wire logic      resetn,
    input  wire logic      cs_n,
    input  wire logic      ior_n_in,
    input  wire logic      iow_n_in,
    input  wire logic [3:0] addr_lo_in,
    input  wire logic [7:0] data_in,
    input  wire logic      eop_n_in,
    input  wire logic      ready,
    input  wire logic      bus_hold_grant,
    input  wire logic [3:0] channel_request_line,
    output dma_pkg::pins_type pins
);
    import dma_pkg::*;

    logic rst_meta_reg, rst_n;

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            rst_meta_reg <= 1'b0;
            rst_n        <= 1'b0;
        end else begin
            rst_meta_reg <= 1'b1;
            rst_n        <= rst_meta_reg;
        end
    end

    function automatic logic [1:0] pick(input logic [3:0] r, input logic [1:0] last,
                                        input logic rot);
        logic [1:0] idx;
        logic       found;
        pick  = '0;
        found = 1'b0;
        for (int i = 0; i < 4; i++) begin
            idx = rot ? 2'(last + 2'(i + 1)) : 2'(i);
            if (!found && r[idx]) begin
                pick  = idx;
                found = 1'b1;
            end
        end
    endfunction : pick

    function automatic logic [7:0] sel_byte(input logic [15:0] v, input logic hi);
        sel_byte = hi ? v[15:8] : v[7:0];
    endfunction : sel_byte

    state_type   state_reg, state_next;
    channel_type chan_reg [4];
    channel_type chan_next [4];
    logic [1:0]  ch_reg, ch_next, last_reg, last_next;
    logic [7:0]  cmd_reg, cmd_next, temp_reg, temp_next;
    logic [3:0]  req_reg, req_next, mask_reg, mask_next, tc_reg, tc_next;
    logic        ptr_reg, ptr_next, mm_reg, mm_next, mmw_reg, mmw_next;
    logic        s1_reg, s1_next, eop_seen_reg, eop_seen_next;
    logic        ior_prev_reg, iow_prev_reg, eop_drive_next;
    pins_type    pins_next;

    logic [3:0]  valid, other;
    logic        prog, wr, rd_end, tc_int, ends, fin_ready, fout_valid;
    logic [1:0]  xch, xch_n;
    logic [15:0] addr_step;
    logic [7:0]  fout_data, rd_byte;
    logic [1:0]  ttype;

    byte_fifo #(.WIDTH(FIFO_WIDTH), .DEPTH(FIFO_DEPTH)) mm_fifo (
        .clk       (clk),
        .rst_n     (rst_n),
        .in_valid  (state_reg == st_s4 && mm_reg && !mmw_reg),
        .in_ready  (fin_ready),
        .in_data   (data_in),
        .out_valid (fout_valid),
        .out_ready (state_reg == st_s4 && mm_reg && mmw_reg),
        .out_data  (fout_data)
    );

    // peripheral requests with programmed polarity, software requests unmasked
    assign valid = cmd_reg[CMD_ENABLE] ?
                   (((channel_request_line ^ {4{cmd_reg[CMD_REQ_LOW]}}) & ~mask_reg)
                    | req_reg) : 4'h0;
    assign prog   = !cs_n && !pins.hold_req && state_reg == st_idle;
    assign wr     = prog && iow_prev_reg && !iow_n_in;
    assign rd_end = prog && !ior_prev_reg && ior_n_in;
    assign xch    = mm_reg ? (mmw_reg ? CH_DST : CH_SRC) : ch_reg;
    assign ttype  = chan_reg[ch_reg].mode[MODE_TYPE_LSB +: 2];

    always_comb begin
        if (!addr_lo_in[3]) begin
            rd_byte = sel_byte(addr_lo_in[0] ? chan_reg[addr_lo_in[2:1]].cur_count
                                             : chan_reg[addr_lo_in[2:1]].cur_addr,
                               ptr_reg);
        end else if (addr_lo_in == OFS_CMD_STATUS) begin
            rd_byte = {valid, tc_reg};
        end else if (addr_lo_in == OFS_MASTER_TEMP) begin
            rd_byte = temp_reg;
        end else begin
            rd_byte = 8'h00;
        end
    end

    always_comb begin
        state_next    = state_reg;
        chan_next     = chan_reg;
        ch_next       = ch_reg;
        last_next     = last_reg;
        cmd_next      = cmd_reg;
        temp_next     = temp_reg;
        req_next      = req_reg;
        mask_next     = mask_reg;
        tc_next       = tc_reg;
        ptr_next      = ptr_reg;
        mm_next       = mm_reg;
        mmw_next      = mmw_reg;
        s1_next       = s1_reg;
        eop_seen_next = eop_seen_reg;
        eop_drive_next = 1'b0;
        tc_int        = 1'b0;
        ends          = 1'b0;
        other         = valid & ~(4'h1 << ch_reg);
        addr_step     = chan_reg[xch].mode[MODE_DEC] ? 16'(chan_reg[xch].cur_addr - 16'h1)
                                                     : 16'(chan_reg[xch].cur_addr + 16'h1);

        if (rd_end) begin
            if (!addr_lo_in[3]) begin
                ptr_next = !ptr_reg;
            end
            if (addr_lo_in == OFS_CMD_STATUS) begin
                tc_next = 4'h0;
            end
        end
        if (wr) begin
            if (!addr_lo_in[3]) begin
                // current and base written together, byte chosen by pointer
                if (addr_lo_in[0]) begin
                    if (ptr_reg) begin
                        chan_next[addr_lo_in[2:1]].cur_count[15:8]  = data_in;
                        chan_next[addr_lo_in[2:1]].base_count[15:8] = data_in;
                    end else begin
                        chan_next[addr_lo_in[2:1]].cur_count[7:0]  = data_in;
                        chan_next[addr_lo_in[2:1]].base_count[7:0] = data_in;
                    end
                end else begin
                    if (ptr_reg) begin
                        chan_next[addr_lo_in[2:1]].cur_addr[15:8]  = data_in;
                        chan_next[addr_lo_in[2:1]].base_addr[15:8] = data_in;
                    end else begin
                        chan_next[addr_lo_in[2:1]].cur_addr[7:0]  = data_in;
                        chan_next[addr_lo_in[2:1]].base_addr[7:0] = data_in;
                    end
                end
                ptr_next = !ptr_reg;
            end else begin
                unique case (addr_lo_in)
                    OFS_CMD_STATUS: cmd_next = data_in;
                    OFS_REQUEST:    req_next[data_in[1:0]] = data_in[2];
                    OFS_MASK_ONE:   mask_next[data_in[1:0]] = data_in[2];
                    OFS_MODE:       chan_next[data_in[1:0]].mode = data_in[7:2];
                    OFS_CLR_PTR:    ptr_next = 1'b0;
                    OFS_MASTER_TEMP: begin
                        cmd_next  = CMD_RESET;
                        req_next  = 4'h0;
                        tc_next   = 4'h0;
                        temp_next = 8'h00;
                        ptr_next  = 1'b0;
                        mask_next = MASK_RESET;
                    end
                    OFS_CLR_MASK:   mask_next = 4'h0;
                    OFS_MASK_ALL:   mask_next = data_in[3:0];
                    default:        ptr_next = ptr_reg;
                endcase
            end
        end

        if (state_reg inside {st_s1, st_s2, st_s3, st_wait} && !eop_n_in && !pins.eop_oe) begin
            eop_seen_next = 1'b1;
        end

        unique case (state_reg)
            st_idle: begin
                if (valid != 4'h0 && !prog) begin
                    ch_next    = pick(valid, last_reg, cmd_reg[CMD_ROTATE]);
                    mm_next    = cmd_reg[CMD_MEM2MEM] && ch_next == CH_SRC;
                    mmw_next   = 1'b0;
                    s1_next    = 1'b1;
                    state_next = st_hold;
                end
            end
            st_hold: begin
                if (bus_hold_grant) begin
                    state_next = s1_reg ? st_s1 : st_s2;
                end
            end
            st_s1: begin
                if (!(mm_reg && !mmw_reg && !fin_ready)) begin
                    state_next = st_s2;
                end
            end
            st_s2: state_next = st_s3;
            st_s3: state_next = ready ? st_s4 : st_wait;
            st_wait: state_next = ready ? st_s4 : st_wait;
            st_s4: begin
                if (!(mm_reg && xch == CH_SRC && cmd_reg[CMD_HOLD_CH0])) begin
                    chan_next[xch].cur_addr = addr_step;
                end
                s1_next = mm_reg || (addr_step[15:8] != chan_reg[xch].cur_addr[15:8]);
                if (mm_reg && mmw_reg) begin
                    temp_next = fout_data;
                end
                if (!mm_reg || mmw_reg) begin
                    chan_next[xch].cur_count = 16'(chan_reg[xch].cur_count - 16'h1);
                    tc_int = chan_reg[xch].cur_count == 16'h0 && (!mm_reg || xch == CH_DST);
                end
                eop_drive_next = tc_int;
                ends = tc_int || eop_seen_reg || !eop_n_in;
                eop_seen_next = 1'b0;
                mmw_next  = mm_reg && !mmw_reg;
                last_next = ch_reg;
                if (ends) begin
                    req_next[ch_reg] = 1'b0;
                    tc_next[mm_reg ? CH_DST : ch_reg] = 1'b1;
                    if (chan_reg[ch_reg].mode[MODE_AUTO]) begin
                        chan_next[ch_reg].cur_addr  = chan_reg[ch_reg].base_addr;
                        chan_next[ch_reg].cur_count = chan_reg[ch_reg].base_count;
                        if (mm_reg) begin
                            chan_next[CH_DST].cur_addr  = chan_reg[CH_DST].base_addr;
                            chan_next[CH_DST].cur_count = chan_reg[CH_DST].base_count;
                        end
                    end else begin
                        mask_next[ch_reg] = 1'b1;
                    end
                end
                if (mm_reg && !ends) begin
                    state_next = st_s1;
                end else if (!ends && !mm_reg
                             && (chan_reg[ch_reg].mode[MODE_SEL_LSB +: 2] == SEL_BLOCK
                                 || (chan_reg[ch_reg].mode[MODE_SEL_LSB +: 2] == SEL_DEMAND
                                     && valid[ch_reg]))) begin
                    state_next = s1_next ? st_s1 : st_s2;
                end else if (other != 4'h0) begin
                    // hold kept: go straight on with the next requester
                    ch_next    = pick(other, ch_reg, cmd_reg[CMD_ROTATE]);
                    mm_next    = 1'b0;
                    mmw_next   = 1'b0;
                    s1_next    = 1'b1;
                    state_next = st_s1;
                end else begin
                    mm_next    = 1'b0;
                    state_next = st_idle;
                end
            end
        endcase
        // tc status: a set in this cycle already overrides the status-read clear above
    end

    always_comb begin
        logic active;
        logic rd_half;
        logic wr_half;
        logic [15:0] xa;
        active   = state_next inside {st_s1, st_s2, st_s3, st_wait, st_s4};
        xch_n    = mm_next ? (mmw_next ? CH_DST : CH_SRC) : ch_next;
        xa       = chan_next[xch_n].cur_addr;
        rd_half  = state_next inside {st_s2, st_s3, st_wait, st_s4};
        wr_half  = state_next inside {st_s3, st_wait, st_s4};
        pins_next = '0;
        pins_next.hold_req   = state_next != st_idle;
        pins_next.upper_address_enable        = active;
        pins_next.upper_address_strobe      = state_next == st_s1;
        pins_next.addr_lo    = xa[3:0];
        pins_next.addr_lo_oe = active;
        pins_next.addr_hi    = xa[7:4];
        pins_next.addr_hi_oe = active;
        pins_next.io_oe      = active && !mm_next;
        pins_next.mem_oe     = active;
        pins_next.eop_oe     = eop_drive_next;
        pins_next.ior_n      = 1'b1;
        pins_next.iow_n      = 1'b1;
        pins_next.memory_read_strobe_n     = 1'b1;
        pins_next.memory_write_strobe_n     = 1'b1;
        if (state_next == st_s1) begin
            pins_next.data    = xa[15:8];
            pins_next.data_oe = 1'b1;
        end else if (mm_next && mmw_next && active) begin
            pins_next.data    = fout_data;
            pins_next.data_oe = 1'b1;
        end else if (prog && !ior_n_in) begin
            pins_next.data    = rd_byte;
            pins_next.data_oe = 1'b1;
        end
        if (active && mm_next) begin
            pins_next.memory_read_strobe_n = !(rd_half && !mmw_next);
            pins_next.memory_write_strobe_n = !(wr_half && mmw_next);
        end else if (active && ttype == TYPE_READ) begin
            pins_next.memory_read_strobe_n = !rd_half;
            pins_next.iow_n  = !wr_half;
        end else if (active && ttype == TYPE_WRITE) begin
            pins_next.ior_n  = !rd_half;
            pins_next.memory_write_strobe_n = !wr_half;
        end
        pins_next.ack = (active && !mm_next) ? (4'h1 << ch_next) : 4'h0;
        if (!cmd_next[CMD_ACK_HIGH]) begin
            pins_next.ack = ~pins_next.ack;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_reg    <= st_idle;
            for (int i = 0; i < 4; i++) begin
                chan_reg[i] <= '0;
            end
            ch_reg       <= '0;
            last_reg     <= 2'h3;
            cmd_reg      <= CMD_RESET;
            temp_reg     <= 8'h00;
            req_reg      <= 4'h0;
            mask_reg     <= MASK_RESET;
            tc_reg       <= 4'h0;
            ptr_reg      <= 1'b0;
            mm_reg       <= 1'b0;
            mmw_reg      <= 1'b0;
            s1_reg       <= 1'b0;
            eop_seen_reg <= 1'b0;
            ior_prev_reg <= 1'b1;
            iow_prev_reg <= 1'b1;
            pins         <= '{ior_n: 1'b1, iow_n: 1'b1, memory_read_strobe_n: 1'b1, memory_write_strobe_n: 1'b1,
                              ack: 4'hf, default: '0};
        end else begin
            state_reg    <= state_next;
            chan_reg     <= chan_next;
            ch_reg       <= ch_next;
            last_reg     <= last_next;
            cmd_reg      <= cmd_next;
            temp_reg     <= temp_next;
            req_reg      <= req_next;
            mask_reg     <= mask_next;
            tc_reg       <= tc_next;
            ptr_reg      <= ptr_next;
            mm_reg       <= mm_next;
            mmw_reg      <= mmw_next;
            s1_reg       <= s1_next;
            eop_seen_reg <= eop_seen_next;
            ior_prev_reg <= ior_n_in;
            iow_prev_reg <= iow_n_in;
            pins         <= pins_next;
        end
    end
endmodule : dma_controller

//--- hdl/dma_pkg.sv
// constants, types and pin group for the four-channel dma controller
// Notes on behaviour
// - external low end_of_process ends active service
// - terminal count drives a low end_of_process pulse
// - end clears request; auto-initialise reloads from base
// - end sets status bit; mask unless auto-initialise
// - memory-to-memory ends on channel 1 terminal count
// - low address lines input idle, output active
// - unmasked valid request raises hold, starts service
// - acknowledge polarity programmable, reset active low
// - upper byte on data with strobe and enable
// - memory strobes follow transfer direction and half
// - io strobes input idle and in memory-to-memory, driven opposite direction in other active service
// - seven one-clock states: idle, hold, working, wait
// - idle samples every request line every clock
// - programming only with chip select low, hold low
// - byte pointer picks low/high byte, cleared by commands
// - software commands decoded from address and write strobe
// - rotating priority makes serviced channel lowest
// - block/demand repeat upper address only on carry
// - current address steps per transfer, two-byte access
// - current count decrements; terminal count at zero
// - base registers written with current, never readable
package dma_pkg;

    localparam logic [3:0] OFS_CMD_STATUS  = 4'h8;
    localparam logic [3:0] OFS_REQUEST     = 4'h9;
    localparam logic [3:0] OFS_MASK_ONE    = 4'ha;
    localparam logic [3:0] OFS_MODE        = 4'hb;
    localparam logic [3:0] OFS_CLR_PTR     = 4'hc;
    localparam logic [3:0] OFS_MASTER_TEMP = 4'hd;
    localparam logic [3:0] OFS_CLR_MASK    = 4'he;
    localparam logic [3:0] OFS_MASK_ALL    = 4'hf;

    localparam int CMD_MEM2MEM  = 0;
    localparam int CMD_HOLD_CH0 = 1;
    localparam int CMD_ENABLE   = 2;
    localparam int CMD_ROTATE   = 4;
    localparam int CMD_REQ_LOW  = 6;
    localparam int CMD_ACK_HIGH = 7;

    localparam int MODE_TYPE_LSB = 0;
    localparam int MODE_AUTO     = 2;
    localparam int MODE_DEC      = 3;
    localparam int MODE_SEL_LSB  = 4;

    localparam logic [1:0] TYPE_VERIFY = 2'h0;
    localparam logic [1:0] TYPE_WRITE  = 2'h1;
    localparam logic [1:0] TYPE_READ   = 2'h2;
    localparam logic [1:0] SEL_DEMAND  = 2'h0;
    localparam logic [1:0] SEL_BLOCK   = 2'h2;

    localparam logic [7:0] CMD_RESET  = 8'h00;
    localparam logic [3:0] MASK_RESET = 4'hf;
    localparam logic [1:0] CH_SRC     = 2'h0;
    localparam logic [1:0] CH_DST     = 2'h1;

    localparam int FIFO_WIDTH = 8;
    localparam int FIFO_DEPTH = 8;

    typedef enum logic [2:0] {
        st_idle, st_hold, st_s1, st_s2, st_s3, st_wait, st_s4
    } state_type;

    typedef struct packed {
        logic [15:0] cur_addr;
        logic [15:0] cur_count;
        logic [15:0] base_addr;
        logic [15:0] base_count;
        logic [5:0]  mode;
    } channel_type;

    typedef struct packed {
        logic [3:0] addr_lo;
        logic       addr_lo_oe;
        logic [3:0] addr_hi;
        logic       addr_hi_oe;
        logic [7:0] data;
        logic       data_oe;
        logic       ior_n;
        logic       iow_n;
        logic       io_oe;
        logic       memory_read_strobe_n;
        logic       memory_write_strobe_n;
        logic       mem_oe;
        logic       eop_oe;
        logic       hold_req;
        logic [3:0] ack;
        logic       upper_address_strobe;
        logic       upper_address_enable;
    } pins_type;

endpackage : dma_pkg

//--- sim/dma_controller_props.sv
// concurrent checks on the dma controller pins
module dma_checker (
    input wire logic              clk,
    input wire logic              resetn,
    input wire logic              bus_hold_grant,
    input wire dma_pkg::pins_type pins
);
    timeunit 1ns;
    timeprecision 1ns;
    import dma_pkg::*;
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!resetn);
    AST_STB_EN: assert property (pins.upper_address_strobe |-> pins.upper_address_enable)
        else $error("strobe outside enable");
    AST_STB_ONE: assert property (pins.upper_address_strobe |=> !pins.upper_address_strobe)
        else $error("strobe longer than one state");
    AST_EOP_ONE: assert property (pins.eop_oe |=> !pins.eop_oe)
        else $error("end pulse longer than one cycle");
    AST_GRANT_FIRST: assert property ($rose(pins.upper_address_enable) |-> $past(bus_hold_grant))
        else $error("service began without grant");
    AST_HOLD_WAIT: assert property (pins.hold_req && !pins.upper_address_enable && !bus_hold_grant |=> !pins.upper_address_enable)
        else $error("left hold wait early");
    AST_ADDR_OE: assert property (pins.addr_hi_oe |-> pins.hold_req)
        else $error("address driven while idle");
    AST_WR_TYPE: assert property (pins.io_oe && !pins.ior_n |-> pins.memory_read_strobe_n)
        else $error("io read with memory read");
    AST_RD_TYPE: assert property (pins.io_oe && !pins.iow_n |-> pins.memory_write_strobe_n)
        else $error("io write with memory write");
    AST_IDLE_FLOAT: assert property (!pins.hold_req && !$past(pins.hold_req) |-> !pins.mem_oe)
        else $error("strobes driven while idle");
endmodule : dma_checker

bind dma_controller dma_checker dma_checker_inst (.clk(clk), .resetn(resetn),
    .bus_hold_grant(bus_hold_grant), .pins(pins));

//--- sim/dma_partner.sv
// host grant and peripheral request model facing the controller
module dma_partner #(
    parameter int GRANT_WAIT = 2
) (
    input  wire logic       clk,
    input  wire logic       hold_req,
    input  wire logic [3:0] ack,
    input  wire logic [3:0] want,
    output logic            grant,
    output logic [3:0]      request
);
    timeunit 1ns;
    timeprecision 1ns;
    int wait_cnt = 0;
    initial grant = 1'b0;
    initial request = 4'h0;
    always @(posedge clk) begin
        if (!hold_req) begin
            wait_cnt <= 0;
            grant <= 1'b0;
        end else if (wait_cnt >= GRANT_WAIT) begin
            grant <= 1'b1;
        end else begin
            wait_cnt <= wait_cnt + 1;
        end
        // acknowledge is active low; request holds until it goes active
        request <= (request | want) & ack;
    end
endmodule : dma_partner

//--- sim/tb_top.sv
// self-checking bench for the dma controller
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin fail_count++; \
    $display("MISMATCH %0t got %h expected %h", $time, g, e); end end
module tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    import dma_pkg::*;
    logic       clk = 1'b0;
    logic       resetn = 1'b0;
    logic       cs_n = 1'b1;
    logic       ior_n = 1'b1;
    logic       iow_n = 1'b1;
    logic [3:0] addr = 4'h0;
    logic [7:0] data = 8'h00;
    logic       ext_n = 1'b1;
    logic [3:0] want = 4'h0;
    logic       grant;
    logic [3:0] request;
    pins_type   pins;
    logic [7:0] rv;
    int         fail_count = 0;
    int         checks_done = 0;
    int         cycles = 0;
    int         strobes = 0;
    int         s0;
    always #20 clk = ~clk;
    dma_controller dma_controller_inst (.clk(clk), .resetn(resetn), .cs_n(cs_n),
        .ior_n_in(ior_n), .iow_n_in(iow_n), .addr_lo_in(addr), .data_in(data),
        .eop_n_in(ext_n & !pins.eop_oe), .ready(1'b1), .bus_hold_grant(grant),
        .channel_request_line(request), .pins(pins));
    dma_partner #(.GRANT_WAIT(2)) dma_partner_inst (.clk(clk), .hold_req(pins.hold_req),
        .ack(pins.ack), .want(want), .grant(grant), .request(request));
    task automatic end_sim();
        $display("checks %0d mismatches %0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : end_sim
    always @(posedge clk) begin
        cycles <= cycles + 1;
        strobes <= strobes + int'(pins.upper_address_strobe);
        if (cycles == 20000) begin
            fail_count++;
            end_sim();
        end
    end
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk);
        cs_n <= 1'b0;
        addr <= a;
        data <= d;
        iow_n <= 1'b0;
        repeat (2) @(posedge clk);
        iow_n <= 1'b1;
        repeat (2) @(posedge clk);
        cs_n <= 1'b1;
    endtask : wr
    task automatic rd(input logic [3:0] a, output logic [7:0] d);
        @(posedge clk);
        cs_n <= 1'b0;
        addr <= a;
        ior_n <= 1'b0;
        repeat (3) @(posedge clk);
        #1 d = pins.data;
        @(posedge clk);
        ior_n <= 1'b1;
        repeat (2) @(posedge clk);
        cs_n <= 1'b1;
    endtask : rd
    task automatic chk16(input logic [3:0] a, input logic [15:0] e);
        logic [7:0] lo;
        logic [7:0] hi;
        rd(a, lo);
        rd(a, hi);
        `CHK({hi, lo}, e)
    endtask : chk16
    task automatic prog(input logic [1:0] ch, input logic [7:0] m, input logic [15:0] ad,
                        input logic [15:0] cn);
        wr(OFS_CLR_PTR, 8'h00);
        wr({1'b0, ch, 1'b0}, ad[7:0]);
        wr({1'b0, ch, 1'b0}, ad[15:8]);
        wr({1'b0, ch, 1'b1}, cn[7:0]);
        wr({1'b0, ch, 1'b1}, cn[15:8]);
        wr(OFS_MODE, m);
    endtask : prog
    task automatic hold_is(input logic lvl);
        for (int n = 0; n < 500 && pins.hold_req !== lvl; n++) begin
            @(posedge clk);
        end
        `CHK(pins.hold_req, lvl)
    endtask : hold_is
    task automatic ask(input int ch);
        @(posedge clk);
        want[ch] <= 1'b1;
        @(posedge clk);
        want <= 4'h0;
    endtask : ask
    initial begin
        repeat (12) @(posedge clk);
        resetn <= 1'b1;
        repeat (3) @(posedge clk);
        prog(2'd0, 8'h48, 16'h1234, 16'h0000);
        rd(4'h0, rv);
        `CHK(rv, 8'h34)
        wr(OFS_CLR_PTR, 8'h00);
        chk16(4'h0, 16'h1234);
        chk16(4'h1, 16'h0000);
        wr(OFS_CLR_MASK, 8'h00);
        ask(0);
        repeat (20) @(posedge clk);
        `CHK(pins.hold_req, 1'b0)
        wr(OFS_CMD_STATUS, 8'h04);
        hold_is(1'b1);
        hold_is(1'b0);
        rd(OFS_CMD_STATUS, rv);
        `CHK(rv, 8'h01)
        chk16(4'h0, 16'h1235);
        chk16(4'h1, 16'hffff);
        ask(0);
        repeat (20) @(posedge clk);
        `CHK(pins.hold_req, 1'b0)
        $display("single transfer test done");
        prog(2'd1, 8'h59, 16'h00ff, 16'h0000);
        wr(OFS_MASK_ALL, 8'h01);
        ask(1);
        hold_is(1'b1);
        hold_is(1'b0);
        chk16(4'h2, 16'h00ff);
        ask(1);
        hold_is(1'b1);
        hold_is(1'b0);
        rd(OFS_CMD_STATUS, rv);
        `CHK(rv, 8'h02)
        $display("auto-initialise test done");
        prog(2'd2, 8'h86, 16'h00fe, 16'h0003);
        s0 = strobes;
        ask(2);
        hold_is(1'b1);
        hold_is(1'b0);
        `CHK(strobes - s0, 2)
        chk16(4'h4, 16'h0102);
        rd(OFS_CMD_STATUS, rv);
        `CHK(rv, 8'h04)
        $display("block carry test done");
        prog(2'd0, 8'h08, 16'h0010, 16'h0005);
        prog(2'd1, 8'h49, 16'h0020, 16'h0000);
        wr(OFS_CMD_STATUS, 8'h05);
        wr(OFS_REQUEST, 8'h04);
        hold_is(1'b1);
        hold_is(1'b0);
        rd(OFS_MASTER_TEMP, rv);
        `CHK(rv, 8'h04)
        rd(OFS_CMD_STATUS, rv);
        `CHK(rv, 8'h02)
        chk16(4'h2, 16'h0021);
        $display("memory to memory test done");
        prog(2'd3, 8'h87, 16'h0000, 16'h0040);
        ask(3);
        for (int n = 0; n < 500 && pins.memory_write_strobe_n !== 1'b0; n++) begin
            @(posedge clk);
        end
        ext_n <= 1'b0;
        repeat (2) @(posedge clk);
        ext_n <= 1'b1;
        hold_is(1'b0);
        chk16(4'h7, 16'h003f);
        rd(OFS_CMD_STATUS, rv);
        `CHK(rv[3:0], 4'h8)
        $display("external end test done");
        end_sim();
    end
endmodule : tb_top
